//--- shared/imr_map.vh
`ifndef IMR_MAP_VH
`define IMR_MAP_VH
// baud reload: one less than a quarter of an scl period in system clocks
`define IMR_BRG_RELOAD_DEF 8'h04
`define IMR_BRG_W          8
// bits in a byte and position of the ack bit
`define IMR_BITS_PER_BYTE  4'h8
`define IMR_ACK_BIT_NUM    4'h9
// reset values and buffer depth
`define IMR_BYTE_RST       8'h00
`define IMR_BUF_DEPTH      2
`endif

//--- logic/imr_pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module imr_pin_sync (
    // clock and reset
    input  wire clk_i,
    input  wire sys_rst_i,
    // pin
    input  wire pin_i,
    output reg  level_o
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1      <= 1'b1;
            s2      <= 1'b1;
            s3      <= 1'b1;
            level_o <= 1'b1;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level_o <= s3;
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/imr_skid_buf.v
`timescale 1ns/1ps
`default_nettype none
`include "imr_map.vh"
// two-entry buffer with valid/ready on both sides
module imr_skid_buf #(
    parameter W = 8
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         sys_rst_i,
    // fill side
    input  wire         in_valid_i,
    input  wire [W-1:0] in_data_i,
    output wire         in_ready_o,
    // drain side
    output wire         out_valid_o,
    output wire [W-1:0] out_data_o,
    input  wire         out_ready_i
);
    reg [W-1:0] mem [0:1];
    reg         wr_ptr;
    reg         rd_ptr;
    reg [1:0]   count;
    wire        push;
    wire        pop;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push & ~pop) begin
                count <= count + 2'h1;
            end else if (pop & ~push) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- logic/imr_master_rx.v
// Operation
// - A receive enable request is ignored unless the port is idle.
// - While receiving, four baud rollovers make one scl clock; the second samples one sda bit into the shifter while scl is high.
// - After the eighth falling scl edge, receive enable clears, the byte goes to the buffer, full and interrupt set, scl held low.
// - After a byte is handed over the port is idle and waits for the next command.
// - Full sets whenever a received data byte enters the buffer and clears on a buffer read.
// - Overflow sets when a byte completes while full is still set.
// - A buffer write during reception sets write collision and is discarded.
// - Start enable produces a start condition and sets the interrupt flag when it completes.
// - A buffer write of the address starts transmission of all eight bits on sda.
// - The slave acknowledge after the address is sampled into the ack status bit.
// - The interrupt flag rises at the end of the ninth clock of an address byte.
// - Ack sequence enable clocks the ack data value out as the ninth bit.
// - The interrupt flag sets once the master ack bit has been clocked out.
// - Receive, capture and ack repeat per byte; a transfer ends with a nack or a stop.
`timescale 1ns/1ps
`default_nettype none
`include "imr_map.vh"
module imr_master_rx #(
    parameter [7:0] BRG_RELOAD = `IMR_BRG_RELOAD_DEF
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       sys_rst_i,
    // software commands (one-cycle pulses)
    input  wire       start_condition_enable_i,
    input  wire       stop_enable_i,
    input  wire       receive_enable_bit_i,
    input  wire       ack_sequence_enable_i,
    input  wire       ack_data_value_i,
    input  wire       buf_wr_i,
    input  wire [7:0] buf_wr_data_i,
    input  wire       buf_rd_i,
    input  wire       int_clr_i,
    input  wire       ovf_clr_i,
    input  wire       write_collision_flag_clr_i,
    // buffer and status
    output reg  [7:0] serial_buffer_register_o,
    output reg        buffer_full_flag_o,
    output reg        serial_interrupt_flag_o,
    output reg        receive_overflow_flag_o,
    output reg        write_collision_flag_o,
    output reg        ack_status_bit_o,
    output reg        receive_enable_bit_o,
    output reg        ack_sequence_enable_o,
    output reg        idle_o,
    // bus pins, oe low while driving low
    input  wire       scl_i,
    output reg        scl_oe_n_o,
    input  wire       sda_i,
    output reg        sda_oe_n_o
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_TX    = 3'h2;
    localparam [2:0] ST_RX    = 3'h3;
    localparam [2:0] ST_ACK   = 3'h4;
    localparam [2:0] ST_STOP  = 3'h5;

    reg  [2:0] state;
    reg  [7:0] brg;
    reg  [1:0] phase;
    reg  [3:0] bit_cnt;
    reg  [7:0] rx_shift_register;
    reg  [7:0] tx_shift;
    reg        ack_val;
    wire       tick;
    wire       scl_s;
    wire       sda_s;
    wire       rxb_valid;
    wire [7:0] rxb_data;
    wire       rxb_ready;
    reg        cap_valid;
    reg  [7:0] cap_data;
    wire       cap_ready;
    wire       busy_rx;
    wire       scl_stretched;

    // true on the last data bit of a byte
    function byte_done;
        input [3:0] cnt;
        begin
            byte_done = (cnt == (`IMR_BITS_PER_BYTE - 4'h1));
        end
    endfunction

    // true on the ninth bit, the acknowledge slot
    function ack_slot;
        input [3:0] cnt;
        begin
            ack_slot = (cnt == `IMR_BITS_PER_BYTE);
        end
    endfunction

    imr_pin_sync u_scl_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (scl_i),
        .level_o   (scl_s)
    );

    imr_pin_sync u_sda_sync (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (sda_i),
        .level_o   (sda_s)
    );

    // captured bytes pass a two-entry buffer before the software buffer
    imr_skid_buf #(
        .W (8)
    ) u_rx_buf (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (cap_valid),
        .in_data_i   (cap_data),
        .in_ready_o  (cap_ready),
        .out_valid_o (rxb_valid),
        .out_data_o  (rxb_data),
        .out_ready_i (rxb_ready)
    );

    // the software buffer takes a word every cycle, so the drain never stalls
    assign rxb_ready = 1'b1;
    assign busy_rx   = (state == ST_RX) | cap_valid;

    // baud generator runs only outside idle; a low scl from the slave stretches
    assign scl_stretched = scl_oe_n_o & ~scl_s;
    assign tick          = (state != ST_IDLE) && (brg == 8'h00) && !scl_stretched;

    always @(posedge clk_i) begin
        if (sys_rst_i || state == ST_IDLE) begin
            brg <= BRG_RELOAD;
        end else if (brg == 8'h00) begin
            if (tick) begin
                brg <= BRG_RELOAD;
            end
        end else begin
            brg <= brg - 8'h01;
        end
    end

    // quarter-period phases: 0 rising, 1 high (sample), 2 falling, 3 low (data change)
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            state                   <= ST_IDLE;
            phase                   <= 2'h0;
            bit_cnt                 <= 4'h0;
            rx_shift_register       <= `IMR_BYTE_RST;
            tx_shift                <= `IMR_BYTE_RST;
            ack_val                 <= 1'b1;
            scl_oe_n_o              <= 1'b1;
            sda_oe_n_o              <= 1'b1;
            idle_o                  <= 1'b1;
            receive_enable_bit_o    <= 1'b0;
            ack_sequence_enable_o   <= 1'b0;
            ack_status_bit_o        <= 1'b0;
            serial_interrupt_flag_o <= 1'b0;
            write_collision_flag_o  <= 1'b0;
            receive_overflow_flag_o <= 1'b0;
            cap_valid               <= 1'b0;
            cap_data                <= `IMR_BYTE_RST;
        end else begin
            if (cap_valid && cap_ready) begin
                cap_valid <= 1'b0;
            end
            // clears come first so that a set further down wins
            if (int_clr_i) begin
                serial_interrupt_flag_o <= 1'b0;
            end
            if (ovf_clr_i) begin
                receive_overflow_flag_o <= 1'b0;
            end
            if (write_collision_flag_clr_i) begin
                write_collision_flag_o <= 1'b0;
            end
            if (buf_wr_i && busy_rx) begin
                write_collision_flag_o <= 1'b1;
            end

            case (state)
                // commands are taken only here: start, stop, write, receive, ack
                ST_IDLE: begin
                    idle_o <= 1'b1;
                    phase  <= 2'h0;
                    if (start_condition_enable_i) begin
                        state  <= ST_START;
                        idle_o <= 1'b0;
                    end else if (stop_enable_i) begin
                        state      <= ST_STOP;
                        sda_oe_n_o <= 1'b0;
                        idle_o     <= 1'b0;
                    end else if (buf_wr_i) begin
                        tx_shift   <= buf_wr_data_i;
                        bit_cnt    <= 4'h0;
                        state      <= ST_TX;
                        sda_oe_n_o <= buf_wr_data_i[7];
                        idle_o     <= 1'b0;
                    end else if (receive_enable_bit_i) begin
                        // accepted only here, in idle
                        receive_enable_bit_o <= 1'b1;
                        bit_cnt              <= 4'h0;
                        sda_oe_n_o           <= 1'b1;
                        state                <= ST_RX;
                        idle_o               <= 1'b0;
                    end else if (ack_sequence_enable_i) begin
                        ack_sequence_enable_o <= 1'b1;
                        ack_val               <= ack_data_value_i;
                        sda_oe_n_o            <= ack_data_value_i;
                        state                 <= ST_ACK;
                        idle_o                <= 1'b0;
                    end
                end

                // start: sda falls while scl is high
                ST_START: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: begin
                            sda_oe_n_o <= 1'b1;
                            scl_oe_n_o <= 1'b1;
                        end
                        2'h1: sda_oe_n_o <= 1'b0;
                        2'h2: scl_oe_n_o <= 1'b0;
                        default: begin
                            serial_interrupt_flag_o <= 1'b1;
                            state                   <= ST_IDLE;
                            idle_o                  <= 1'b1;
                        end
                    endcase
                end

                // bit eight is the slave's acknowledge slot
                ST_TX: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: scl_oe_n_o <= 1'b1;
                        2'h1: begin
                            if (ack_slot(bit_cnt)) begin
                                ack_status_bit_o <= sda_s;
                            end
                        end
                        2'h2: scl_oe_n_o <= 1'b0;
                        default: begin
                            bit_cnt <= bit_cnt + 4'h1;
                            if (ack_slot(bit_cnt)) begin
                                // end of the ninth clock
                                serial_interrupt_flag_o <= 1'b1;
                                state                   <= ST_IDLE;
                                idle_o                  <= 1'b1;
                            end else if (byte_done(bit_cnt)) begin
                                sda_oe_n_o <= 1'b1;
                            end else begin
                                tx_shift   <= {tx_shift[6:0], 1'b0};
                                sda_oe_n_o <= tx_shift[6];
                            end
                        end
                    endcase
                end

                // sample on the high quarter, once the synchroniser has settled
                ST_RX: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: scl_oe_n_o <= 1'b1;
                        2'h1: rx_shift_register <= {rx_shift_register[6:0], sda_s};
                        2'h2: scl_oe_n_o <= 1'b0;
                        default: begin
                            bit_cnt <= bit_cnt + 4'h1;
                            if (byte_done(bit_cnt)) begin
                                // eighth falling edge: hand byte over, scl stays low
                                receive_enable_bit_o <= 1'b0;
                                cap_valid            <= 1'b1;
                                cap_data             <= rx_shift_register;
                                if (buffer_full_flag_o) begin
                                    receive_overflow_flag_o <= 1'b1;
                                end
                                serial_interrupt_flag_o <= 1'b1;
                                state                   <= ST_IDLE;
                                idle_o                  <= 1'b1;
                            end
                        end
                    endcase
                end

                // sda stays low after the ack bit so that a stop can follow
                ST_ACK: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: scl_oe_n_o <= 1'b1;
                        2'h1: sda_oe_n_o <= ack_val;
                        2'h2: scl_oe_n_o <= 1'b0;
                        default: begin
                            sda_oe_n_o              <= 1'b0;
                            ack_sequence_enable_o   <= 1'b0;
                            serial_interrupt_flag_o <= 1'b1;
                            state                   <= ST_IDLE;
                            idle_o                  <= 1'b1;
                        end
                    endcase
                end

                // stop: scl up, then sda up while scl is high
                ST_STOP: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: scl_oe_n_o <= 1'b1;
                        2'h1: sda_oe_n_o <= 1'b1;
                        2'h2: serial_interrupt_flag_o <= 1'b1;
                        default: begin
                            state  <= ST_IDLE;
                            idle_o <= 1'b1;
                        end
                    endcase
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // software buffer and full flag; a new byte wins over a same-cycle read
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            serial_buffer_register_o <= `IMR_BYTE_RST;
            buffer_full_flag_o       <= 1'b0;
        end else if (rxb_valid) begin
            serial_buffer_register_o <= rxb_data;
            buffer_full_flag_o       <= 1'b1;
        end else begin
            if (buf_rd_i) begin
                buffer_full_flag_o <= 1'b0;
            end
            if (buf_wr_i && !busy_rx && state == ST_IDLE) begin
                serial_buffer_register_o <= buf_wr_data_i;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/imr_master_rx_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module imr_master_rx_monitor #(
    parameter [7:0] BRG_RELOAD = 8'h04
) (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // commands
    input wire logic       start_condition_enable_i,
    input wire logic       stop_enable_i,
    input wire logic       receive_enable_bit_i,
    input wire logic       ack_sequence_enable_i,
    input wire logic       ack_data_value_i,
    input wire logic       buf_wr_i,
    input wire logic       buf_rd_i,
    // status
    input wire logic [7:0] serial_buffer_register_o,
    input wire logic       buffer_full_flag_o,
    input wire logic       serial_interrupt_flag_o,
    input wire logic       receive_overflow_flag_o,
    input wire logic       write_collision_flag_o,
    input wire logic       receive_enable_bit_o,
    input wire logic       ack_sequence_enable_o,
    input wire logic       idle_o,
    // pins
    input wire logic       scl_oe_n_o,
    input wire logic       sda_oe_n_o
);
    localparam int BIT = 4 * (BRG_RELOAD + 1);
    localparam int BIT_HI = BIT + 10;
    localparam int ADDR_LO = 9 * BIT - 10;
    localparam int ADDR_HI = 9 * BIT + 10;
    localparam int RX_LO = 8 * BIT - 10;
    localparam int RX_HI = 8 * BIT + 10;
    logic        no_hi;
    logic        ack_take;
    logic        ack_val;
    logic [11:0] rx_cnt;
    assign no_hi = !start_condition_enable_i && !stop_enable_i && !buf_wr_i;
    assign ack_take = idle_o && ack_sequence_enable_i && no_hi && !receive_enable_bit_i;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_val <= 1'b1;
            rx_cnt  <= 12'h000;
        end else begin
            if (ack_take)
                ack_val <= ack_data_value_i;
            rx_cnt <= receive_enable_bit_o ? rx_cnt + 12'h001 : 12'h000;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_rx_go;
        idle_o && receive_enable_bit_i && no_hi;
    endsequence
    sequence s_rx_end;
        $fell(receive_enable_bit_o);
    endsequence
    sequence s_wr_go;
        idle_o && buf_wr_i && !start_condition_enable_i && !stop_enable_i
            && !serial_interrupt_flag_o;
    endsequence
    sequence s_start_go;
        idle_o && start_condition_enable_i && !serial_interrupt_flag_o;
    endsequence
    a_rx_refused: assert property (
        receive_enable_bit_i && !idle_o && !receive_enable_bit_o |=> !receive_enable_bit_o)
        else $error("receive enable taken while busy");
    a_rx_accept: assert property (
        s_rx_go |=> receive_enable_bit_o && !idle_o)
        else $error("receive enable not taken in idle");
    a_rx_length: assert property (
        s_rx_end |-> $past(rx_cnt) >= RX_LO && $past(rx_cnt) <= RX_HI)
        else $error("reception not eight bit times long");
    a_rx_end_state: assert property (
        s_rx_end |-> serial_interrupt_flag_o && idle_o && !scl_oe_n_o)
        else $error("end of reception state wrong");
    a_full_set: assert property (
        s_rx_end |-> ##[0:4] buffer_full_flag_o)
        else $error("full flag not set after byte");
    a_rd_clear: assert property (
        buf_rd_i && buffer_full_flag_o && !receive_overflow_flag_o |=> !buffer_full_flag_o)
        else $error("buffer read did not clear full");
    a_ovf_set: assert property (
        s_rx_end ##0 buffer_full_flag_o |-> ##[0:4] receive_overflow_flag_o)
        else $error("overflow not flagged");
    a_write_collision_flag_keep: assert property (
        buf_wr_i && receive_enable_bit_o |=>
            write_collision_flag_o && $stable(serial_buffer_register_o))
        else $error("write during reception not refused");
    a_start_int: assert property (
        s_start_go |-> ##[1:BIT_HI] serial_interrupt_flag_o)
        else $error("no interrupt after start");
    a_addr_int: assert property (
        s_wr_go |-> ##[ADDR_LO:ADDR_HI] serial_interrupt_flag_o)
        else $error("no interrupt after nine address clocks");
    a_ack_value: assert property (
        ack_sequence_enable_o && scl_oe_n_o |-> sda_oe_n_o == ack_val)
        else $error("ack bit level wrong");
    a_ack_done: assert property (
        ack_take |-> ##[BIT:BIT_HI] !ack_sequence_enable_o && serial_interrupt_flag_o)
        else $error("ack sequence did not finish");
endmodule
bind imr_master_rx imr_master_rx_monitor #(.BRG_RELOAD(BRG_RELOAD)) imr_master_rx_monitor_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_condition_enable_i(start_condition_enable_i),
    .stop_enable_i(stop_enable_i), .receive_enable_bit_i(receive_enable_bit_i),
    .ack_sequence_enable_i(ack_sequence_enable_i), .ack_data_value_i(ack_data_value_i),
    .buf_wr_i(buf_wr_i), .buf_rd_i(buf_rd_i),
    .serial_buffer_register_o(serial_buffer_register_o),
    .buffer_full_flag_o(buffer_full_flag_o), .serial_interrupt_flag_o(serial_interrupt_flag_o),
    .receive_overflow_flag_o(receive_overflow_flag_o),
    .write_collision_flag_o(write_collision_flag_o),
    .receive_enable_bit_o(receive_enable_bit_o), .ack_sequence_enable_o(ack_sequence_enable_o),
    .idle_o(idle_o), .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o));
`default_nettype wire

//--- verification/imr_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module imr_slave_model (
    // bus levels
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output var  logic       sda_oe_n_o,
    // byte to send, address seen
    input  wire logic [7:0] tx_byte_i,
    output var  logic [7:0] addr_o
);
    logic       act = 1'b0;
    logic       adr_ph = 1'b0;
    logic [3:0] bitn = 4'h0;
    logic [7:0] sh = 8'h00;
    initial sda_oe_n_o = 1'b1;
    initial addr_o = 8'h00;
    // start and stop are sda edges while scl is high
    always @(negedge sda_i) begin
        if (scl_i === 1'b1) begin
            act = 1'b1;
            adr_ph = 1'b1;
            bitn = 4'h0;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i === 1'b1) begin
            act = 1'b0;
            sda_oe_n_o = 1'b1;
        end
    end
    always @(posedge scl_i) begin
        if (act) begin
            if (bitn < 4'h8)
                sh = {sh[6:0], sda_i};
            // a nack from the master ends our sending
            if (!adr_ph && bitn == 4'h8 && sda_i)
                act = 1'b0;
            if (adr_ph && bitn == 4'h8) begin
                addr_o = sh;
                adr_ph = 1'b0;
            end
            bitn = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
        end
    end
    // data changes only while scl is low; released line is pulled high
    always @(negedge scl_i) begin
        if (!act)
            sda_oe_n_o = 1'b1;
        else if (adr_ph)
            sda_oe_n_o = (bitn != 4'h8);
        else if (bitn < 4'h8)
            sda_oe_n_o = tx_byte_i[7 - bitn];
        else
            sda_oe_n_o = 1'b1;
    end
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb;
    logic       clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic [8:0] cmd = 9'h000;
    logic       ackv = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] tx_byte = 8'h00;
    logic [7:0] d;
    logic [7:0] exp_buf;
    wire  [7:0] slv_addr;
    wire  [7:0] buf_q;
    wire        full, intf, ovf, write_collision_flag, ackst, rxen, ack_sequence_enable, idle;
    wire        scl_oe_n, sda_oe_n, slv_oe_n;
    wire        scl_w = scl_oe_n;
    wire        sda_w = sda_oe_n & slv_oe_n;
    int         mismatches = 0;
    int         n_tests = 0;
    int         b;
    int         i;
    always #50 clk_i = ~clk_i;
    imr_master_rx imr_master_rx_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .start_condition_enable_i(cmd[0]), .stop_enable_i(cmd[1]),
        .receive_enable_bit_i(cmd[2]), .ack_sequence_enable_i(cmd[3]),
        .ack_data_value_i(ackv), .buf_wr_i(cmd[4]), .buf_wr_data_i(wdata),
        .buf_rd_i(cmd[5]), .int_clr_i(cmd[6]), .ovf_clr_i(cmd[7]), .write_collision_flag_clr_i(cmd[8]),
        .serial_buffer_register_o(buf_q), .buffer_full_flag_o(full),
        .serial_interrupt_flag_o(intf), .receive_overflow_flag_o(ovf),
        .write_collision_flag_o(write_collision_flag), .ack_status_bit_o(ackst),
        .receive_enable_bit_o(rxen), .ack_sequence_enable_o(ack_sequence_enable), .idle_o(idle),
        .scl_i(scl_w), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_oe_n_o(sda_oe_n));
    imr_slave_model imr_slave_model_i (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_n_o(slv_oe_n),
        .tx_byte_i(tx_byte), .addr_o(slv_addr));
    function automatic logic [7:0] exp_addr(input logic [6:0] a);
        return {a, 1'b1};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one-cycle command pulse, then one idle cycle
    task automatic pulse(input int k);
        cmd[k] = 1'b1;
        tick(1);
        cmd = 9'h000;
        tick(1);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_int(input string nm);
        int k;
        for (k = 0; k < 2000 && intf !== 1'b1; k++)
            tick(1);
        `CHK(nm, 1'b1, intf)
        if (k == 2000)
            test_done();
        pulse(6);
    endtask
    initial begin
        void'($urandom(76192));
        tick(8);
        sys_rst_i = 1'b0;
        `CHK("idle", 1'b1, idle)
        `CHK("oe", 2'b11, {scl_oe_n, sda_oe_n})
        pulse(0);
        pulse(2);
        `CHK("rx refused", 1'b0, rxen)
        wait_int("start int");
        wdata = exp_addr(7'($urandom));
        exp_buf = wdata;
        tx_byte = 8'($urandom);
        pulse(4);
        wait_int("addr int");
        `CHK("addr seen", wdata, slv_addr)
        `CHK("ack status", 1'b0, ackst)
        for (b = 0; b < 4; b++) begin
            d = tx_byte;
            pulse(2);
            `CHK("rx taken", 1'b1, rxen)
            wdata = 8'($urandom);
            pulse(4);
            `CHK("write_collision_flag", 1'b1, write_collision_flag)
            if (b < 2)
                `CHK("buf kept", exp_buf, buf_q)
            pulse(8);
            wait_int("rx int");
            tick(4);
            if (b == 2) begin
                `CHK("overflow", 1'b1, ovf)
                for (i = 0; i < 4 && full === 1'b1; i++)
                    pulse(5);
                pulse(7);
                `CHK("ovf clr", 1'b0, ovf)
            end else begin
                `CHK("rx byte", d, buf_q)
                `CHK("full", 1'b1, full)
                exp_buf = d;
                if (b != 1) begin
                    pulse(5);
                    `CHK("full clr", 1'b0, full)
                end
            end
            tx_byte = (b == 0) ? 8'h00 : (b == 2) ? 8'hFF : 8'($urandom);
            ackv = (b == 3);
            pulse(3);
            wait_int("ack int");
            `CHK("ack clr", 1'b0, ack_sequence_enable)
        end
        pulse(1);
        wait_int("stop int");
        tick(4);
        `CHK("idle end", 1'b1, idle)
        `CHK("sda free", 1'b1, sda_w)
        test_done();
    end
endmodule
`default_nettype wire
